// >>> core/p3bc_port.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
// Port 3 per-pin control with Wishbone register access
module p3bc_port
  import p3bc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [p3bc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [p3bc_pkg::NPINS-1:0] pin_i,
  output logic [p3bc_pkg::NPINS-1:0] pin_o,
  output logic [p3bc_pkg::NPINS-1:0] pin_oe_n_o,
  // Drive sources from neighbouring blocks
  input wire logic [p3bc_pkg::NPINS-1:0] pulse_train_i,
  input wire logic [p3bc_pkg::NPINS-2:0] flash_rate_i,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_en_i,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_oe_i,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_dat_i,
  // Edge event towards the device interrupt line
  output logic irq_o,
  output logic event_o
);
  import p3bc_pkg::*;

  // Per-pin control storage, then interrupt, bus and output registers
  logic [NPINS-1:0] dir_q; // Direction, shared with port-wide register
  logic [NPINS-1:0] data_q; // Data latch, shared with port-wide register
  logic [NPINS-1:0] pts_q; // Pulse-train select
  logic [FC_W-1:0] fc_q [NPINS]; // Function code per pin
  logic [1:0] byp_q [NPINS]; // Bypass field, odd pins only
  logic [IDX_W-1:0] src_q; // Interrupt source register
  logic irq_q; // Pending interrupt
  logic ack_q; // Bus acknowledge
  logic [31:0] rdat_q; // Registered read data
  logic [NPINS-1:0] pin_q; // Registered pin value
  logic [NPINS-1:0] oe_n_q; // Registered output enable
  logic event_q; // One-cycle event pulse

  // Bus decode
  wire [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_go = req && wb_we_i && wb_sel_i[0];
  wire rd_go = req && !wb_we_i;
  wire hit_pin = (idx >= PIN0_IDX) && (idx <= PIN7_IDX);
  wire hit_dir = (idx == PORT_DIR_IDX);
  wire hit_data = (idx == PORT_DATA_IDX);
  wire hit_src = (idx == INT_SRC_IDX);
  wire [2:0] pin_sel = idx[2:0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wr_dir = wr_go && hit_dir;
  wire wr_data = wr_go && hit_data;
  // Reading the source register acknowledges the interrupt
  wire src_read = rd_go && hit_src;

  // Per-pin derived signals
  logic [NPINS-1:0] wr_pin; // Write strobe per pin register
  logic [NPINS-1:0] byp_on; // Pin echoes its even partner
  logic [NPINS-1:0] bit_drive; // Output value under bit control
  logic [NPINS-1:0] pin_d; // Resolved output value
  logic [NPINS-1:0] oe_n_d; // Resolved output enable, low drives
  logic [NPINS-1:0] edge_arm; // Edge detection allowed
  logic [NPINS-1:0] edge_hit; // Qualified edge per pin
  logic [7:0] rd_byte [NPINS]; // Read view of each pin register
  logic [NPINS-1:0] dir_view;

  genvar k;
  generate
    for (k = 0; k < NPINS; k++)
    begin : g_pin
      // Each register answers only for its own pin
      assign wr_pin[k] = wr_go && hit_pin && (pin_sel == 3'(k));

      // Direction: one bit, two write paths
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          dir_q[k] <= DIR_RST;
        else if (ce_i && wr_pin[k])
          dir_q[k] <= wbyte[DIR_BIT];
        else if (ce_i && wr_dir)
          dir_q[k] <= wbyte[k];
      end

      // Data latch: one bit, two write paths
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          data_q[k] <= DATA_RST;
        else if (ce_i && wr_pin[k])
          data_q[k] <= wbyte[DATA_BIT];
        else if (ce_i && wr_data)
          data_q[k] <= wbyte[k];
      end

      // Pulse-train select and function code
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pts_q[k] <= PTS_RST;
          fc_q[k] <= FC_RST;
        end
        else if (ce_i && wr_pin[k])
        begin
          pts_q[k] <= wbyte[PTS_BIT];
          fc_q[k] <= wbyte[FC_MSB:FC_LSB];
        end
      end

      if (k % 2 == 1)
      begin : g_odd
        // Bypass field stored only on odd pins
        always_ff @(posedge clk_i)
        begin
          if (rst_i)
            byp_q[k] <= BYP_RST;
          else if (ce_i && wr_pin[k])
            byp_q[k] <= wbyte[BYP_MSB:BYP_LSB];
        end
        assign byp_on[k] = (byp_q[k] != BYP_RST);
      end
      else
      begin : g_even
        // Even pins hold no bypass bits and read them as zero
        assign byp_q[k] = BYP_RST;
        assign byp_on[k] = 1'b0;
      end

      // Bit control output: steady, flashing or pulse train
      assign bit_drive[k] = pts_q[k] ? pulse_train_i[fc_q[k]] :
                            (fc_q[k] == FC_STEADY) ? data_q[k] :
                            (data_q[k] && flash_rate_i[fc_q[k] - 3'h1]);

      // Priority: bypass, then drive bypass control, then bit control
      if (k % 2 == 1)
      begin : g_odd_out
        assign pin_d[k] = byp_on[k] ? pin_i[k-1] :
                          drive_bypass_en_i[k] ? drive_bypass_dat_i[k] :
                          bit_drive[k];
      end
      else
      begin : g_even_out
        assign pin_d[k] = drive_bypass_en_i[k] ? drive_bypass_dat_i[k] :
                          bit_drive[k];
      end
      assign oe_n_d[k] = byp_on[k] ? 1'b0 :
                         drive_bypass_en_i[k] ? !drive_bypass_oe_i[k] :
                         dir_q[k];

      // Edges count only while the pin is a plain bit-control input
      assign edge_arm[k] = dir_q[k] && !pts_q[k] && !byp_on[k] && !drive_bypass_en_i[k];

      // Read view: data bit shows the pin, never the latch
      assign rd_byte[k] = {pts_q[k], byp_q[k], fc_q[k], dir_q[k], pin_i[k]};
      assign dir_view[k] = dir_q[k];

      // Filtered transition detector
      p3bc_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(pin_i[k]),
        .arm_i(edge_arm[k]),
        .mode_i(fc_q[k]),
        .edge_o(edge_hit[k])
      );
    end
  endgenerate

  // Lowest-numbered pin wins when several edges meet
  logic [2:0] first_pin;
  always_comb
  begin
    first_pin = 3'h0;
    for (int i = NPINS - 1; i >= 0; i--)
    begin
      if (edge_hit[i])
        first_pin = 3'(i);
    end
  end
  wire any_edge = |edge_hit;
  wire [IDX_W-1:0] src_d = PIN0_IDX + IDX_W'(first_pin);

  // Read data selection; unmapped addresses read zero
  wire [7:0] rd_sel = hit_pin ? rd_byte[pin_sel] :
                      hit_dir ? dir_view :
                      hit_data ? pin_i :
                      hit_src ? src_q :
                      8'h00;

  // Bus answer: ack one cycle after the request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_q <= req;
      if (rd_go)
        rdat_q <= {24'h00_0000, rd_sel};
    end
  end

  // Interrupt source and pending flag; a new edge beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q <= SRC_RST;
      irq_q <= 1'b0;
      event_q <= 1'b0;
    end
    else if (ce_i)
    begin
      event_q <= any_edge;
      if (any_edge)
      begin
        src_q <= src_d;
        irq_q <= 1'b1;
      end
      else if (src_read)
        irq_q <= 1'b0;
    end
  end

  // Pin outputs registered for clean timing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_q <= {NPINS{DATA_RST}};
      oe_n_q <= {NPINS{DIR_RST}};
    end
    else if (ce_i)
    begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pin_o = pin_q;
  assign pin_oe_n_o = oe_n_q;
  assign irq_o = irq_q;
  assign event_o = event_q;
endmodule : p3bc_port

// >>> core/p3bc_pkg.sv
// Overview of operation
// - Eight per-pin registers, each steering one pin
// - Direction/data bits shared with port-wide registers
// - Drive bypass control overrides bit control, not the bypass field
// - Reset clears pulse-train select in every register
// - Pulse-train select: function code picks train
// - Bypass field makes odd pin echo even
// - Bypass field exists only on odd pins
// - Priority: bypass, drive bypass, then bit control
// - Function code sets flash rate or edges
// - Direction set tri-states pin as input
// - Data drives output; reads return pin level
// - Filtered edge raises interrupt, records source register index
package p3bc_pkg;
  // Pin count and widths
  localparam int unsigned NPINS = 8;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned ADR_W = 10;
  localparam int unsigned FC_W = 3;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] PIN0_IDX = 8'hB0;
  localparam logic [IDX_W-1:0] PIN7_IDX = 8'hB7;
  localparam logic [IDX_W-1:0] PORT_DIR_IDX = 8'hA0;
  localparam logic [IDX_W-1:0] PORT_DATA_IDX = 8'hA1;
  localparam logic [IDX_W-1:0] INT_SRC_IDX = 8'hA2;
  // Field positions inside a per-pin register
  localparam int unsigned DATA_BIT = 0;
  localparam int unsigned DIR_BIT = 1;
  localparam int unsigned FC_LSB = 2;
  localparam int unsigned FC_MSB = 4;
  localparam int unsigned BYP_LSB = 5;
  localparam int unsigned BYP_MSB = 6;
  localparam int unsigned PTS_BIT = 7;
  // Reset values
  localparam logic DIR_RST = 1'b1;
  localparam logic DATA_RST = 1'b1;
  localparam logic PTS_RST = 1'b0;
  localparam logic [FC_W-1:0] FC_RST = 3'h0;
  localparam logic [1:0] BYP_RST = 2'h0;
  localparam logic [IDX_W-1:0] SRC_RST = 8'h00;
  // Function codes for plain output and input edge choice
  localparam logic [FC_W-1:0] FC_STEADY = 3'h0;
  localparam logic [FC_W-1:0] FC_EDGE_NONE = 3'h0;
  localparam logic [FC_W-1:0] FC_EDGE_RISE = 3'h1;
  localparam logic [FC_W-1:0] FC_EDGE_FALL = 3'h2;
  localparam logic [FC_W-1:0] FC_EDGE_BOTH = 3'h3;
  // Input transition filter: level must hold this long
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned FILTER_NS = 20;
  localparam int unsigned FILTER_CYC_RAW = (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FILTER_CYC = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;
  localparam int unsigned FCNT_W = 4;
  localparam logic [FCNT_W-1:0] FCNT_ZERO = 4'h0;
  localparam logic [FCNT_W-1:0] FCNT_ONE = 4'h1;
  localparam logic [FCNT_W-1:0] FCNT_LAST = FCNT_W'(FILTER_CYC - 1);
  // Edge detector states
  typedef enum logic [1:0] {
    P3BC_FLT_IDLE,
    P3BC_FLT_WAIT
  } p3bc_flt_state_t;
endpackage : p3bc_pkg

// >>> core/p3bc_edge_det.sv
`timescale 1ns/1ns
// Filters one input pin and flags a qualified transition
module p3bc_edge_det
  import p3bc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic arm_i,
  input wire logic [p3bc_pkg::FC_W-1:0] mode_i,
  output logic edge_o
);
  import p3bc_pkg::*;

  p3bc_flt_state_t state_q; // Filter state
  p3bc_flt_state_t state_d;
  logic level_q; // Accepted filtered level
  logic [FCNT_W-1:0] cnt_q; // Cycles the new level has held
  logic [FCNT_W-1:0] cnt_d;
  logic level_d;
  logic edge_d;
  wire differs = (pin_i != level_q);
  wire settled = (cnt_q == FCNT_LAST);
  // Edge kind chosen by the function code
  wire want_rise = (mode_i == FC_EDGE_RISE) || (mode_i == FC_EDGE_BOTH);
  wire want_fall = (mode_i == FC_EDGE_FALL) || (mode_i == FC_EDGE_BOTH);

  // Next-state logic: a new level must hold before it counts
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    level_d = level_q;
    edge_d = 1'b0;
    case (state_q)
      P3BC_FLT_IDLE:
      begin
        // Start timing a change
        if (differs)
        begin
          state_d = P3BC_FLT_WAIT;
          cnt_d = FCNT_ONE;
        end
      end
      P3BC_FLT_WAIT:
      begin
        if (!differs)
        begin
          // Glitch: drop it
          state_d = P3BC_FLT_IDLE;
          cnt_d = FCNT_ZERO;
        end
        else if (settled)
        begin
          // Valid transition accepted
          state_d = P3BC_FLT_IDLE;
          cnt_d = FCNT_ZERO;
          level_d = pin_i;
          edge_d = arm_i && ((pin_i && want_rise) || (!pin_i && want_fall));
        end
        else
        begin
          cnt_d = cnt_q + FCNT_ONE;
        end
      end
      default:
      begin
        state_d = P3BC_FLT_IDLE;
        cnt_d = FCNT_ZERO;
      end
    endcase
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= P3BC_FLT_IDLE;
      cnt_q <= FCNT_ZERO;
      level_q <= DATA_RST;
      edge_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
      edge_o <= edge_d;
    end
  end
endmodule : p3bc_edge_det

// >>> verif/p3bc_port_props.sv
`timescale 1ns/1ns
// Bus, pin and event checks on the port block
module p3bc_port_props
  import p3bc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [p3bc_pkg::NPINS-1:0] pin_o,
  input wire logic [p3bc_pkg::NPINS-1:0] pin_oe_n_o,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_en_i,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_oe_i,
  input wire logic [p3bc_pkg::NPINS-1:0] drive_bypass_dat_i,
  input wire logic irq_o,
  input wire logic event_o
);
  // One clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Request answered one cycle after it is taken
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // Even pin 0 has no pair bypass, so drive bypass owns it
  a_drive_byp_pin0: assert property ($past(drive_bypass_en_i[0] && ce_i && !rst_i) |->
    pin_oe_n_o[0] == !$past(drive_bypass_oe_i[0]) && pin_o[0] == $past(drive_bypass_dat_i[0]))
    else $error("drive bypass lost on pin 0");
  // Reset leaves every pin an input, no interrupt, no ack
  a_reset_inputs: assert property (disable iff (1'b0) rst_i && ce_i |=>
    pin_oe_n_o == 8'hFF && !irq_o && !wb_ack_o)
    else $error("reset state wrong");
  a_event_pulse: assert property (event_o && ce_i |=> !event_o)
    else $error("event longer than one cycle");
  a_irq_with_event: assert property (event_o |-> irq_o)
    else $error("event without interrupt");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> event_o)
    else $error("interrupt without event");
  // Only a bus access may clear a pending interrupt
  a_irq_sticky: assert property (irq_o && !(wb_cyc_i && wb_stb_i) |=> irq_o)
    else $error("interrupt dropped by itself");
  c_irq: cover property ($rose(irq_o));
  c_drive_byp: cover property (drive_bypass_en_i[0] ##1 drive_bypass_en_i[0]);
  c_ack: cover property (wb_ack_o);
endmodule : p3bc_port_props

// >>> verif/port3_per_pin_bit_control_test.sv
`timescale 1ns/1ns
// Compare and count
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
// Self-checking bench for the port block
module port3_per_pin_bit_control_test;
  import p3bc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic wb_ack, irq, evt;
  logic [7:0] pin_i = 8'hA5, pin_o, pin_oe_n, pt = 8'h96;
  logic [7:0] db_en = 8'h00, db_oe = 8'h00, db_dat = 8'h00;
  logic [6:0] fr = 7'h4B;
  logic [7:0] rd;
  int err_count = 0, num_checks = 0;
  // Clock, 4 ns period
  always #2 clk_i = ~clk_i;
  p3bc_port DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .pulse_train_i(pt), .flash_rate_i(fr),
    .drive_bypass_en_i(db_en), .drive_bypass_oe_i(db_oe),
    .drive_bypass_dat_i(db_dat), .irq_o(irq), .event_o(evt));
  // Classic single Wishbone cycle; read byte lands in rd
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  // Read one register and compare
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, ex, rd)
  endtask : rchk
  // Reset values of all pin registers
  task automatic t_reset;
    `CHK("oe_n_rst", 8'hFF, pin_oe_n)
    for (int k = 0; k < 8; k++) rchk("pin_reg", 8'hB0 + 8'(k), {7'h01, pin_i[k]});
    rchk("port_dir", 8'hA0, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  // Shared direction and data storage, pin drive
  task automatic t_shared;
    bus(1'b1, 8'hB3, 8'h01);
    rchk("dir_shared", 8'hA0, 8'hF7);
    repeat (3) @(posedge clk_i);
    `CHK("oe_n_own", 8'hF7, pin_oe_n)
    `CHK("pin3_hi", 1'b1, pin_o[3])
    rchk("pin3_level", 8'hB3, 8'h00);
    bus(1'b1, 8'hA1, 8'h00);
    repeat (3) @(posedge clk_i);
    `CHK("pin3_lo", 1'b0, pin_o[3])
    bus(1'b1, 8'hA0, 8'hFF);
    rchk("dir_back", 8'hB3, 8'h02);
    `CHK("pin3_in", 1'b1, pin_oe_n[3])
    $display("test shared done");
  endtask : t_shared
  // Pulse trains and flash rates on pin 3
  task automatic t_drive;
    for (int f = 0; f < 8; f++)
    begin
      bus(1'b1, 8'hB3, 8'h80 | 8'(f * 4));
      repeat (3) @(posedge clk_i);
      `CHK("pulse", pt[f], pin_o[3])
      if (f > 0)
      begin
        bus(1'b1, 8'hB3, 8'(f * 4 + 1));
        repeat (3) @(posedge clk_i);
        `CHK("flash", fr[f-1], pin_o[3])
      end
    end
    $display("test drive done");
  endtask : t_drive
  // Pair bypass, drive bypass and their priority
  task automatic t_bypass;
    @(posedge clk_i);
    db_en <= 8'h03;
    db_oe <= 8'h01;
    db_dat <= 8'h01;
    for (int b = 1; b < 4; b++)
    begin
      bus(1'b1, 8'hB1, 8'(b * 32));
      for (int v = 0; v < 2; v++)
      begin
        @(posedge clk_i);
        pin_i[0] <= v[0];
        repeat (3) @(posedge clk_i);
        `CHK("byp_oe_n", 1'b0, pin_oe_n[1])
        `CHK("byp_echo", v[0], pin_o[1])
      end
    end
    `CHK("db_pin0", 2'b01, {pin_oe_n[0], pin_o[0]})
    rchk("byp_odd", 8'hB1, 8'h60);
    bus(1'b1, 8'hB0, 8'h62);
    rchk("byp_even", 8'hB0, 8'h03);
    // Bypass cleared before the pin returns to plain input use
    bus(1'b1, 8'hB1, 8'h02);
    repeat (3) @(posedge clk_i);
    `CHK("db_pin1", 1'b1, pin_oe_n[1])
    db_en <= 8'h00;
    $display("test bypass done");
  endtask : t_bypass
  // Filtered rising edge on pin 5
  task automatic t_edge;
    @(posedge clk_i);
    pin_i[5] <= 1'b0;
    // Direction change first, edge enable in a separate write
    bus(1'b1, 8'hB5, 8'h02);
    bus(1'b1, 8'hB5, 8'h06);
    repeat (10) @(posedge clk_i);
    pin_i[5] <= 1'b1;
    repeat (3) @(posedge clk_i);
    pin_i[5] <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK("glitch", 1'b0, irq)
    pin_i[5] <= 1'b1;
    // Fifth differing sample accepts, event pulse follows one edge later
    repeat (7) @(posedge clk_i);
    `CHK("event_pulse", 1'b1, evt)
    repeat (3) @(posedge clk_i);
    `CHK("event_gone", 1'b0, evt)
    `CHK("irq_set", 1'b1, irq)
    rchk("src", 8'hA2, 8'hB5);
    repeat (3) @(posedge clk_i);
    `CHK("irq_clr", 1'b0, irq)
    $display("test edge done");
  endtask : t_edge
  // Unmapped places read zero and ignore writes
  task automatic t_unmapped;
    rchk("unmapped", 8'h10, 8'h00);
    bus(1'b1, 8'hB8, 8'hFF);
    rchk("past_b7", 8'hB8, 8'h00);
    $display("test unmapped done");
  endtask : t_unmapped
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_shared();
    t_drive();
    t_bypass();
    t_edge();
    t_unmapped();
    tally_and_finish();
  end
  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule : port3_per_pin_bit_control_test
bind p3bc_port p3bc_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .drive_bypass_en_i(drive_bypass_en_i),
  .drive_bypass_oe_i(drive_bypass_oe_i), .drive_bypass_dat_i(drive_bypass_dat_i),
  .irq_o(irq_o), .event_o(event_o));
